// *** verilog/erxsc_top.sv ***
// Receive status counters with APB register access
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module erxsc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_done,
	input wire logic [7:0] rx_desc_used,
	input wire logic rx_ovf_drop,
	input wire logic tx_busy_in,
	input wire logic rx_busy_in,
	input wire logic txn_busy_in,
	output logic rx_halt,
	output logic packet_pending_flag,
	output logic packet_pending_irq,
	output logic rx_overflow_flag_set,
	output logic module_on
);
	erxsc_pkg::erxsc_ctrl_s ctrl_reg;
	erxsc_pkg::erxsc_stat_s stat_reg;
	logic [7:0] count_reg;
	logic busy_reg;
	logic tx_act_reg;
	logic rx_act_reg;
	logic [15:0] drop_reg;
	logic [7:0] cnt_next;
	logic [15:0] drop_next;
	logic [31:0] rdata_next;
	logic acc, wr, rd, hit;
	logic dec_req, inc_req, low_lanes;
	logic [8:0] inc_sum;

	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] d, input logic [11:0] a);
		case (a)
			erxsc_pkg::ERXSC_SET_OFF: wmerge = old | d;
			erxsc_pkg::ERXSC_CLR_OFF: wmerge = old & ~d;
			erxsc_pkg::ERXSC_INV_OFF: wmerge = old ^ d;
			default: wmerge = d;
		endcase
	endfunction : wmerge

	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (s[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		end
		lane_merge = r;
	endfunction : lane_merge

	assign acc = psel && penable && clk_en;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign pready = 1'b1;
	assign hit = (paddr == erxsc_pkg::ERXSC_STATUS_OFF)
		|| (paddr == erxsc_pkg::ERXSC_DROP_OFF)
		|| (paddr == erxsc_pkg::ERXSC_CTRL_OFF)
		|| (paddr == erxsc_pkg::ERXSC_CLR_OFF)
		|| (paddr == erxsc_pkg::ERXSC_SET_OFF)
		|| (paddr == erxsc_pkg::ERXSC_INV_OFF)
		|| (paddr == erxsc_pkg::ERXSC_RXST_OFF);
	assign pslverr = psel && penable && !hit;
	assign low_lanes = pstrb[0] || pstrb[1];
	assign stat_reg = '{count: count_reg, module_active: busy_reg,
		transmit_active: tx_act_reg, receive_active: rx_act_reg};

	// Control writes (plain, set, clear, invert); decrement is a strobe
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_reg <= '0;
		else if (wr && (paddr == erxsc_pkg::ERXSC_CTRL_OFF
			|| paddr == erxsc_pkg::ERXSC_SET_OFF
			|| paddr == erxsc_pkg::ERXSC_CLR_OFF
			|| paddr == erxsc_pkg::ERXSC_INV_OFF))
		begin
			logic [31:0] cur;
			logic [31:0] nv;
			cur = '0;
			cur[erxsc_pkg::ERXSC_CTRL_ON_BIT] = ctrl_reg.on;
			cur[erxsc_pkg::ERXSC_CTRL_AFC_BIT] = ctrl_reg.auto_fc;
			cur[erxsc_pkg::ERXSC_CTRL_PIE_BIT] = ctrl_reg.pend_ie;
			nv = lane_merge(cur, wmerge(cur, pwdata, paddr), pstrb)
				& erxsc_pkg::ERXSC_CTRL_WMASK;
			ctrl_reg.on <= nv[erxsc_pkg::ERXSC_CTRL_ON_BIT];
			ctrl_reg.auto_fc <= nv[erxsc_pkg::ERXSC_CTRL_AFC_BIT];
			ctrl_reg.pend_ie <= nv[erxsc_pkg::ERXSC_CTRL_PIE_BIT];
		end
	end

	// Decrement request: a write with the decrement bit set and byte lane 0 strobed, at CTRL or SET only
	assign dec_req = wr && pwdata[erxsc_pkg::ERXSC_CTRL_DEC_BIT]
		&& pstrb[0] && (paddr == erxsc_pkg::ERXSC_CTRL_OFF
		|| paddr == erxsc_pkg::ERXSC_SET_OFF);
	assign inc_req = rx_done && clk_en && (rx_desc_used != 8'h00);
	assign inc_sum = {1'b0, stat_reg.count} + {1'b0, rx_desc_used};

	always_comb
	begin
		cnt_next = stat_reg.count;
		if (inc_req && dec_req)
			cnt_next = stat_reg.count;
		else if (inc_req)
			cnt_next = inc_sum[8] ? erxsc_pkg::ERXSC_CNT_MAX
				: inc_sum[7:0];
		else if (dec_req && stat_reg.count != 8'h00)
			cnt_next = stat_reg.count - 8'h01;
	end

	// Buffer count; not touched by the on bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_reg <= erxsc_pkg::ERXSC_CNT_RST;
		else if (wr && paddr == erxsc_pkg::ERXSC_RXST_OFF)
			count_reg <= erxsc_pkg::ERXSC_CNT_RST;
		else if (clk_en)
			count_reg <= cnt_next;
	end

	// Activity flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy_reg <= 1'b0;
			tx_act_reg <= 1'b0;
			rx_act_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			busy_reg <= ctrl_reg.on || txn_busy_in;
			tx_act_reg <= ctrl_reg.on && tx_busy_in;
			rx_act_reg <= ctrl_reg.on && rx_busy_in;
		end
	end

	// Dropped frame counter: increment applies after clear-on-read, so both in one cycle give one
	always_comb
	begin
		drop_next = drop_reg;
		if (rd && paddr == erxsc_pkg::ERXSC_DROP_OFF && low_lanes)
			drop_next = erxsc_pkg::ERXSC_DROP_RST;
		if (rx_ovf_drop)
			drop_next = drop_next + 16'h0001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			drop_reg <= erxsc_pkg::ERXSC_DROP_RST;
		else if (clk_en)
			drop_reg <= drop_next;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_overflow_flag_set <= 1'b0;
		else if (clk_en)
			rx_overflow_flag_set <= rx_ovf_drop;
	end

	always_comb
	begin
		rdata_next = '0;
		case (paddr)
			erxsc_pkg::ERXSC_STATUS_OFF:
			begin
				rdata_next[erxsc_pkg::ERXSC_CNT_LSB +: 8] = stat_reg.count;
				rdata_next[erxsc_pkg::ERXSC_BUSY_BIT] = stat_reg.module_active;
				rdata_next[erxsc_pkg::ERXSC_TXACT_BIT] =
					stat_reg.transmit_active;
				rdata_next[erxsc_pkg::ERXSC_RXACT_BIT] =
					stat_reg.receive_active;
			end
			erxsc_pkg::ERXSC_DROP_OFF: rdata_next[15:0] = drop_reg;
			erxsc_pkg::ERXSC_CTRL_OFF:
			begin
				rdata_next[erxsc_pkg::ERXSC_CTRL_ON_BIT] = ctrl_reg.on;
				rdata_next[erxsc_pkg::ERXSC_CTRL_AFC_BIT] = ctrl_reg.auto_fc;
				rdata_next[erxsc_pkg::ERXSC_CTRL_PIE_BIT] = ctrl_reg.pend_ie;
			end
			default: rdata_next = '0;
		endcase
	end

	// Read data registered in the setup cycle, so it is valid in access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (clk_en && psel && !penable && !pwrite)
			prdata <= rdata_next;
	end

	assign packet_pending_flag = (stat_reg.count != 8'h00);
	assign packet_pending_irq = packet_pending_flag && ctrl_reg.pend_ie;
	assign rx_halt = ctrl_reg.auto_fc
		&& (stat_reg.count == erxsc_pkg::ERXSC_CNT_MAX);
	assign module_on = ctrl_reg.on;
endmodule : erxsc_top

// *** include/erxsc_pkg.sv ***
// Package of constants and carrier types for the receive status counters
package erxsc_pkg;
	localparam logic [11:0] ERXSC_STATUS_OFF = 12'h000;
	localparam logic [11:0] ERXSC_DROP_OFF = 12'h004;
	localparam logic [11:0] ERXSC_CTRL_OFF = 12'h008;
	localparam logic [11:0] ERXSC_CLR_OFF = 12'h00c;
	localparam logic [11:0] ERXSC_SET_OFF = 12'h010;
	localparam logic [11:0] ERXSC_INV_OFF = 12'h014;
	localparam logic [11:0] ERXSC_RXST_OFF = 12'h018;
	localparam int ERXSC_CNT_LSB = 16;
	localparam int ERXSC_BUSY_BIT = 7;
	localparam int ERXSC_TXACT_BIT = 6;
	localparam int ERXSC_RXACT_BIT = 5;
	localparam int ERXSC_CTRL_DEC_BIT = 0;
	localparam int ERXSC_CTRL_ON_BIT = 15;
	localparam int ERXSC_CTRL_AFC_BIT = 1;
	localparam int ERXSC_CTRL_PIE_BIT = 2;
	localparam logic [7:0] ERXSC_CNT_MAX = 8'hff;
	localparam logic [7:0] ERXSC_CNT_RST = 8'h00;
	localparam logic [15:0] ERXSC_DROP_RST = 16'h0000;
	localparam logic [31:0] ERXSC_CTRL_WMASK = 32'h0000_8006;
	typedef struct packed {
		logic on;
		logic auto_fc;
		logic pend_ie;
	} erxsc_ctrl_s;
	typedef struct packed {
		logic [7:0] count;
		logic module_active;
		logic transmit_active;
		logic receive_active;
	} erxsc_stat_s;
endpackage : erxsc_pkg

// *** verif/erxsc_monitor.sv ***
// Checker of port relations of the receive status counters
`timescale 1ns/10ps
module erxsc_monitor (
	input wire logic pclk, presetn, clk_en, psel, penable, pwrite,
	input wire logic [11:0] paddr,
	input wire logic [7:0] rx_desc_used,
	input wire logic rx_done, rx_ovf_drop, rx_halt, packet_pending_flag,
	input wire logic rx_overflow_flag_set
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_wr; psel && penable && pwrite && clk_en; endsequence
	sequence s_inc; rx_done && clk_en && rx_desc_used != 8'h00; endsequence
	property p_clr;
		s_wr ##0 paddr == erxsc_pkg::ERXSC_RXST_OFF |=> !packet_pending_flag;
	endproperty
	a_clr: assert property (p_clr) else $error("count not cleared");
	property p_inc; s_inc ##0 !psel |=> packet_pending_flag; endproperty
	a_inc: assert property (p_inc) else $error("no increment");
	property p_zero;
		!packet_pending_flag && !rx_done |=> !packet_pending_flag;
	endproperty
	a_zero: assert property (p_zero) else $error("count wrapped");
	property p_halt; rx_halt |-> packet_pending_flag; endproperty
	a_halt: assert property (p_halt) else $error("halt at zero");
	property p_hold; rx_halt && !psel |=> rx_halt; endproperty
	a_hold: assert property (p_hold) else $error("halt lost");
	property p_ovf; rx_ovf_drop && clk_en |=> rx_overflow_flag_set; endproperty
	a_ovf: assert property (p_ovf) else $error("no overflow flag");
	property p_set;
		rx_overflow_flag_set |-> $past(rx_ovf_drop) || !$past(clk_en);
	endproperty
	a_set: assert property (p_set) else $error("stray overflow flag");
	property p_fall;
		$fell(packet_pending_flag) |-> $past(psel && pwrite);
	endproperty
	a_fall: assert property (p_fall) else $error("pending fell");
endmodule : erxsc_monitor
bind erxsc_top erxsc_monitor u_erxsc_monitor (.*);

// *** verif/test_eth_rx_status_counters.sv ***
// Self-checking testbench of the receive status counters
`timescale 1ns/10ps
module test_eth_rx_status_counters;
	localparam logic [11:0] CTRL = erxsc_pkg::ERXSC_CTRL_OFF;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
	logic rx_done, rx_ovf_drop, tx_busy_in, rx_busy_in, txn_busy_in, rx_halt;
	logic packet_pending_flag, packet_pending_irq, rx_overflow_flag_set;
	logic module_on;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [7:0] rx_desc_used;
	int errors = 0;
	int check_count = 0;
	erxsc_top u_erxsc_top (.*);
	task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
		check_count++;
		errors += int'(got !== exp);
		if (got !== exp)
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
	endtask : chk
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		#1;
	endtask : apb
	task automatic inc(logic [7:0] n, int w);
		repeat (w) @(posedge pclk);
		{rx_done, rx_desc_used} <= {1'b1, n};
		@(posedge pclk);
		rx_done <= 1'b0;
		#1;
	endtask : inc
	task automatic st(logic [31:0] e);
		apb(1'b0, erxsc_pkg::ERXSC_STATUS_OFF, 32'h0, 4'hf);
		chk("status", rd, e);
	endtask : st
	task automatic t_count;
		apb(1'b1, erxsc_pkg::ERXSC_RXST_OFF, 32'h0, 4'hf);
		inc(8'h03, 1);
		st(32'h0003_0000);
		apb(1'b1, CTRL, 32'h5, 4'hf);
		st(32'h0002_0000);
		chk("irq", packet_pending_irq, 1'b1);
		fork
			apb(1'b1, CTRL, 32'h5, 4'hf);
			inc(8'h01, 2);
		join
		st(32'h0002_0000);
		apb(1'b0, CTRL, 32'h0, 4'hf);
		chk("control", rd, 32'h4);
		apb(1'b1, erxsc_pkg::ERXSC_CLR_OFF, 32'h4, 4'hf);
		chk("irq", packet_pending_irq, 1'b0);
		inc(8'hff, 1);
		st(32'h00ff_0000);
		apb(1'b1, CTRL, 32'h8002, 4'hf);
		chk("halt", rx_halt, 1'b1);
		apb(1'b1, CTRL, 32'h8003, 4'hf);
		chk("halt", rx_halt, 1'b0);
		apb(1'b1, CTRL, 32'h0, 4'hf);
		inc(8'h05, 1);
		chk("halt", rx_halt, 1'b0);
		st(32'h00ff_0000);
		apb(1'b1, erxsc_pkg::ERXSC_RXST_OFF, 32'h0, 4'hf);
		st(32'h0);
		$display("count test done");
	endtask : t_count
	task automatic t_act;
		@(posedge pclk);
		{tx_busy_in, rx_busy_in, txn_busy_in} <= 3'b111;
		apb(1'b1, CTRL, 32'h8000, 4'hf);
		chk("on", module_on, 1'b1);
		@(posedge pclk);
		st(32'h0000_00e0);
		apb(1'b1, CTRL, 32'h0, 4'hf);
		@(posedge pclk);
		st(32'h0000_0080);
		$display("activity test done");
	endtask : t_act
	task automatic t_drop;
		repeat (3)
		begin
			@(posedge pclk);
			rx_ovf_drop <= 1'b1;
			@(posedge pclk);
			rx_ovf_drop <= 1'b0;
			#1 chk("overflow", rx_overflow_flag_set, 1'b1);
		end
		apb(1'b0, erxsc_pkg::ERXSC_DROP_OFF, 32'h0, 4'h0);
		chk("drop", rd, 32'h3);
		apb(1'b0, erxsc_pkg::ERXSC_DROP_OFF, 32'h0, 4'hf);
		chk("drop", rd, 32'h3);
		apb(1'b0, erxsc_pkg::ERXSC_DROP_OFF, 32'h0, 4'hf);
		chk("drop", rd, 32'h0);
		@(posedge pclk);
		{clk_en, rx_ovf_drop} <= 2'b01;
		@(posedge pclk);
		{clk_en, rx_ovf_drop} <= 2'b10;
		apb(1'b0, erxsc_pkg::ERXSC_DROP_OFF, 32'h0, 4'hf);
		chk("frozen", rd, 32'h0);
		apb(1'b0, 12'hffc, 32'h0, 4'hf);
		chk("slverr", err, 1'b1);
		$display("drop test done");
	endtask : t_drop
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	initial forever #5 pclk = ~pclk;
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, rx_done, rx_ovf_drop} = '0;
		{tx_busy_in, rx_busy_in, txn_busy_in, paddr, pwdata, pstrb} = '0;
		rx_desc_used = 8'h00;
		clk_en = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_count;
		t_act;
		t_drop;
		final_report;
	end
	initial
	begin
		repeat (1000) @(posedge pclk);
		errors++;
		final_report;
	end
endmodule : test_eth_rx_status_counters
